//--- verilog/drss_pkg.sv
// Package with register map, field layout, request codes and widths of the request selector.
package drss_pkg;
   // Register byte offsets on the APB side.
   localparam logic [7:0] CHAN_CTRL_BASE = 8'h00;
   localparam logic [7:0] XFER_COUNT_BASE = 8'h10;
   localparam logic [7:0] DMA_OPERATION_OFS = 8'h20;
   localparam int NUM_CHAN = 4;
   localparam int CHAN_IDX_W = 2;
   // Channel control register fields.
   localparam int CHAN_ENABLE_BIT = 0;
   localparam int XFER_END_BIT = 1;
   localparam int REQ_SEL_LSB = 8;
   localparam int REQ_SEL_W = 5;
   // Operation register fields.
   localparam int MASTER_ENABLE_BIT = 0;
   localparam int NMI_ABORT_BIT = 1;
   localparam int ADDR_ERR_BIT = 2;
   // Reset values.
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam int COUNT_W = 16;
   // Request source codes.
   localparam logic [4:0] REQ_AUTO = 5'h00;
   localparam logic [4:0] REQ_TX0 = 5'h01;
   localparam logic [4:0] REQ_RX4 = 5'h0A;
   localparam logic [4:0] REQ_CONV0 = 5'h0B;
   localparam logic [4:0] REQ_CONV1 = 5'h0C;
   localparam logic [4:0] REQ_CAN_RX = 5'h0F;
   localparam logic [4:0] REQ_TIMER_FIRST = 5'h11;
   localparam logic [4:0] REQ_TIMER_LAST = 5'h1C;
   localparam int REQ_LINES_W = 32;
   // Transfer command word: channel index then request code.
   localparam int CMD_W = CHAN_IDX_W + REQ_SEL_W;
   typedef logic [CMD_W-1:0] drss_cmd_t;
endpackage

//--- verilog/drss_stream_if.sv
// Interface carrying transfer commands with valid and ready.
`timescale 1ns/1ps
interface drss_stream_if;
   import drss_pkg::*;
   logic valid;
   logic ready;
   drss_cmd_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- verilog/drss_cmd_buffer.sv
// Two-entry command buffer whose outputs come straight from flip-flops.
`timescale 1ns/1ps
module drss_cmd_buffer (
   input wire logic clk_sys, // System clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic clrAll, // Standby clear.
   drss_stream_if.snk inS, // Filling side.
   drss_stream_if.src outS // Draining side.
);
   import drss_pkg::*;
   logic headValid_reg;
   logic spareValid_reg;
   drss_cmd_t head_reg;
   drss_cmd_t spare_reg;
   logic push;
   logic pop;

   ////////////////////////////////////////////////////////////////////////////////
   // The spare slot absorbs one word while the receiver stalls, so nothing is lost.
   assign push = inS.valid & ~spareValid_reg;
   assign pop = headValid_reg & outS.ready;
   assign inS.ready = ~spareValid_reg;
   assign outS.valid = headValid_reg;
   assign outS.data = head_reg;

   // Head and spare move together as one small pipeline.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || clrAll) begin
         headValid_reg <= 1'b0;
         spareValid_reg <= 1'b0;
         head_reg <= '0;
         spare_reg <= '0;
      end else if (pop) begin
         if (spareValid_reg) begin
            head_reg <= spare_reg;
            spareValid_reg <= 1'b0;
         end else begin
            head_reg <= inS.data;
            headValid_reg <= push;
         end
      end else if (push) begin
         if (headValid_reg) begin
            spare_reg <= inS.data;
            spareValid_reg <= 1'b1;
         end else begin
            head_reg <= inS.data;
            headValid_reg <= 1'b1;
         end
      end
   end
endmodule

//--- verilog/drss_req_select.sv
// Per-channel decoder from request source code to the selected trigger line.
`timescale 1ns/1ps
module drss_req_select (
   input wire logic [drss_pkg::REQ_SEL_W-1:0] reqSel, // Request source code.
   input wire logic [drss_pkg::REQ_LINES_W-1:0] periphReq, // Request lines by code.
   output logic autoMode, // Code picks internal auto-request.
   output logic reqLine // Selected peripheral request level.
);
   import drss_pkg::*;

   // Legal peripheral codes: serial, converters, network receive and timer events.
   function automatic logic isPeriphCode(input logic [REQ_SEL_W-1:0] c);
      isPeriphCode = (c >= REQ_TX0 && c <= REQ_CONV1) || (c == REQ_CAN_RX) ||
         (c >= REQ_TIMER_FIRST && c <= REQ_TIMER_LAST);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // A reserved code yields no line at all, so it can never trigger a transfer.
   always_comb begin
      autoMode = (reqSel == REQ_AUTO);
      reqLine = isPeriphCode(reqSel) & periphReq[reqSel];
   end
endmodule

//--- verilog/drss_top.sv
// Request source selector and channel sequencer of a four-channel DMA controller.
//
// Function
// - Each channel picks auto or one peripheral line by a five-bit code.
// - A peripheral request comes from the source or destination module.
// - Auto mode raises the channel request internally, no external signal.
// - Auto channel runs when enables are 1 and end/abort/error flags 0.
// - Peripheral mode: one transfer per request assertion while enabled.
// - The peripheral interrupt request line serves as the transfer trigger.
// - Peripheral lines: timer, serial tx/rx, network receive, converters.
// - Serial 0 transmit is code 1, receive code 2, then alternating.
// - Serial 4 receive-full is code 10, source its receive data.
// - One code selects network receive, message words 0 to 15 as source.
// - Simultaneous requests served channel 0 first, then 1, 2, 3.
// - Each unit decrements the count; end flag set when it hits zero.
// - Address error or nmi sets its abort flag and stops all channels.
`timescale 1ns/1ps
module drss_top (
   input wire logic clk_sys, // System clock, 20 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic standby, // Standby mode, clears state like reset except pready, prdata and pslverr.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   input wire logic [drss_pkg::REQ_LINES_W-1:0] periphReq, // Request lines by code.
   input wire logic nmiIn, // Non-maskable interrupt event.
   input wire logic addrErrIn, // Address error raised by the transfer engine.
   output logic xferValid, // Transfer command pending.
   output logic [drss_pkg::CHAN_IDX_W-1:0] xferChan, // Channel of the command.
   output logic [drss_pkg::REQ_SEL_W-1:0] xferCode, // Request code of the command.
   input wire logic xferReady // Engine takes the command.
);
   import drss_pkg::*;

   logic [31:0] chanCtrl_reg [NUM_CHAN];
   logic [COUNT_W-1:0] xferCount_reg [NUM_CHAN];
   logic masterEnable_reg;
   logic nmiAbort_reg;
   logic addrErr_reg;
   logic [NUM_CHAN-1:0] teSeen_reg;
   logic nmiSeen_reg;
   logic aeSeen_reg;
   logic [NUM_CHAN-1:0] reqPrev_reg;
   logic [NUM_CHAN-1:0] pending_reg;
   logic [NUM_CHAN-1:0] autoMode;
   logic [NUM_CHAN-1:0] reqLine;
   logic [NUM_CHAN-1:0] chanOk;
   logic [NUM_CHAN-1:0] want;
   logic [NUM_CHAN-1:0] grant;
   logic [CHAN_IDX_W-1:0] grantIdx;
   logic wrEn;
   logic rdEn;
   logic [3:0] wrIdx;
   drss_cmd_t cmdNext;
   drss_stream_if toBuf ();
   drss_stream_if fromBuf ();

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode shared by reads and writes; index 15 means unmapped.
   function automatic logic [3:0] regIndex(input logic [7:0] a);
      if (a[1:0] != 2'b00) begin
         regIndex = 4'hF;
      end else if (a < XFER_COUNT_BASE) begin
         regIndex = {2'b00, a[3:2]};
      end else if (a < DMA_OPERATION_OFS) begin
         regIndex = {2'b01, a[3:2]};
      end else if (a == DMA_OPERATION_OFS) begin
         regIndex = 4'h8;
      end else begin
         regIndex = 4'hF;
      end
   endfunction

   // Writes and reads take effect only in the cycle that completes the access.
   assign wrIdx = regIndex(paddr);
   assign wrEn = psel & penable & pready & pwrite;
   assign rdEn = psel & penable & pready & ~pwrite;

   // One wait state: ready rises in the second access cycle, then drops.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   // Read data and error are prepared together with ready.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pslverr <= (wrIdx == 4'hF);
         prdata <= 32'h0000_0000;
         if (!pwrite) begin
            if (wrIdx < 4'h4) begin
               prdata <= chanCtrl_reg[wrIdx[1:0]];
            end else if (wrIdx < 4'h8) begin
               prdata <= {16'h0000, xferCount_reg[wrIdx[1:0]]};
            end else if (wrIdx == 4'h8) begin
               prdata <= {29'h0000_0000, addrErr_reg, nmiAbort_reg, masterEnable_reg};
            end
         end
      end else begin
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel decoders turn the five-bit code into auto mode or one line.
   generate
      for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : gSel
         drss_req_select uSel (
            .reqSel(chanCtrl_reg[ch][REQ_SEL_LSB+:REQ_SEL_W]),
            .periphReq(periphReq),
            .autoMode(autoMode[ch]),
            .reqLine(reqLine[ch])
         );
      end
   endgenerate

   // A channel is enabled only with both enables set and no end, nmi or error flag.
   always_comb begin
      for (int ch = 0; ch < NUM_CHAN; ch++) begin
         chanOk[ch] = chanCtrl_reg[ch][CHAN_ENABLE_BIT] & masterEnable_reg &
            ~chanCtrl_reg[ch][XFER_END_BIT] & ~nmiAbort_reg & ~addrErr_reg;
         want[ch] = chanOk[ch] & (autoMode[ch] | pending_reg[ch]);
      end
   end

   // Fixed priority: the lowest numbered requesting channel wins.
   always_comb begin
      grant = '0;
      grantIdx = '0;
      for (int ch = NUM_CHAN - 1; ch >= 0; ch--) begin
         if (want[ch]) begin
            grant = '0;
            grant[ch] = toBuf.ready;
            grantIdx = CHAN_IDX_W'(ch);
         end
      end
      cmdNext = {grantIdx, chanCtrl_reg[grantIdx][REQ_SEL_LSB+:REQ_SEL_W]};
   end

   assign toBuf.valid = |want;
   assign toBuf.data = cmdNext;

   ////////////////////////////////////////////////////////////////////////////////
   // Each rising edge of the selected line arms one transfer; a served one disarms.
   // A request that arrives while one is still queued merges into it, so a peripheral
   // must not raise a second request before its first has been served.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || standby) begin
         reqPrev_reg <= '0;
         pending_reg <= '0;
      end else begin
         reqPrev_reg <= reqLine;
         for (int ch = 0; ch < NUM_CHAN; ch++) begin
            if (reqLine[ch] && !reqPrev_reg[ch] && !autoMode[ch]) begin
               pending_reg[ch] <= 1'b1;
            end else if (grant[ch] || !chanOk[ch]) begin
               pending_reg[ch] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channel control: software fields, plus the end flag set by the sequencer.
   // The end flag clears only by a zero write after it was read as one.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || standby) begin
         for (int ch = 0; ch < NUM_CHAN; ch++) begin
            chanCtrl_reg[ch] <= CTRL_RESET;
         end
         teSeen_reg <= '0;
      end else begin
         for (int ch = 0; ch < NUM_CHAN; ch++) begin
            if (wrEn && wrIdx == 4'(ch)) begin
               chanCtrl_reg[ch][CHAN_ENABLE_BIT] <= pwdata[CHAN_ENABLE_BIT];
               chanCtrl_reg[ch][REQ_SEL_LSB+:REQ_SEL_W] <= pwdata[REQ_SEL_LSB+:REQ_SEL_W];
               if (teSeen_reg[ch] && !pwdata[XFER_END_BIT]) begin
                  chanCtrl_reg[ch][XFER_END_BIT] <= 1'b0;
                  teSeen_reg[ch] <= 1'b0;
               end
            end
            if (rdEn && wrIdx == 4'(ch) && chanCtrl_reg[ch][XFER_END_BIT]) begin
               teSeen_reg[ch] <= 1'b1;
            end
            // Set wins over a clear in the same cycle.
            if (grant[ch] && xferCount_reg[ch] == COUNT_W'(1)) begin
               chanCtrl_reg[ch][XFER_END_BIT] <= 1'b1;
            end
         end
      end
   end

   // Transfer counts: software loads them, each issued unit takes one off.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || standby) begin
         for (int ch = 0; ch < NUM_CHAN; ch++) begin
            xferCount_reg[ch] <= COUNT_RESET;
         end
      end else begin
         for (int ch = 0; ch < NUM_CHAN; ch++) begin
            if (grant[ch]) begin
               xferCount_reg[ch] <= xferCount_reg[ch] - COUNT_W'(1);
            end else if (wrEn && wrIdx == 4'(ch + 4)) begin
               xferCount_reg[ch] <= pwdata[COUNT_W-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Operation register. Abort flags are set by hardware only and, like the end flag,
   // need a read of one before a zero write clears them; a new event wins the tie.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || standby) begin
         masterEnable_reg <= 1'b0;
         nmiAbort_reg <= 1'b0;
         addrErr_reg <= 1'b0;
         nmiSeen_reg <= 1'b0;
         aeSeen_reg <= 1'b0;
      end else begin
         if (wrEn && wrIdx == 4'h8) begin
            masterEnable_reg <= pwdata[MASTER_ENABLE_BIT];
            if (nmiSeen_reg && !pwdata[NMI_ABORT_BIT]) begin
               nmiAbort_reg <= 1'b0;
               nmiSeen_reg <= 1'b0;
            end
            if (aeSeen_reg && !pwdata[ADDR_ERR_BIT]) begin
               addrErr_reg <= 1'b0;
               aeSeen_reg <= 1'b0;
            end
         end
         if (rdEn && wrIdx == 4'h8) begin
            nmiSeen_reg <= nmiSeen_reg | nmiAbort_reg;
            aeSeen_reg <= aeSeen_reg | addrErr_reg;
         end
         if (nmiIn) begin
            nmiAbort_reg <= 1'b1;
         end
         if (addrErrIn) begin
            addrErr_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Commands queue in a two-entry buffer; a stalled engine holds back the sequencer.
   // The code travels with the command so the engine may pick burst or cycle steal.
   drss_cmd_buffer uBuf (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clrAll(standby),
      .inS(toBuf.snk),
      .outS(fromBuf.src)
   );

   assign fromBuf.ready = xferReady;
   assign xferValid = fromBuf.valid;
   assign xferChan = fromBuf.data[CMD_W-1:REQ_SEL_W];
   assign xferCode = fromBuf.data[REQ_SEL_W-1:0];
endmodule

//--- testbench/drss_asserts.sv
// Checker of the request selector's port behaviour, bound to the top module.
`timescale 1ns/1ps
module drss_asserts (
   input wire logic clk_sys, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic standby, // Standby clear.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic [31:0] prdata, // APB read data.
   input wire logic pready, // APB ready.
   input wire logic pslverr, // APB error.
   input wire logic xferValid, // Command valid.
   input wire logic [drss_pkg::CHAN_IDX_W-1:0] xferChan, // Command channel.
   input wire logic [drss_pkg::REQ_SEL_W-1:0] xferCode, // Command code.
   input wire logic xferReady // Engine ready.
);
   import drss_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Register access answers once, one cycle after the access phase starts.
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   chk_ready_cause: assert property (psel && penable && !pready |=> pready)
      else $error("access phase got no answer in the next cycle");
   chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error answer without ready or with data");
   // A pending command must not change or vanish while the engine stalls.
   chk_cmd_holds: assert property (xferValid && !xferReady && !standby |=>
      xferValid && $stable(xferChan) && $stable(xferCode))
      else $error("command changed while stalled");
   chk_reserved_code: assert property (xferValid |->
      !(xferCode inside {5'h0D, 5'h0E, 5'h10, [5'h1D:5'h1F]}))
      else $error("command issued for a reserved code");
   chk_code_range: assert property (xferValid |-> xferCode <= REQ_TIMER_LAST)
      else $error("command code beyond the last request line");
   // Reset and standby leave nothing pending.
   chk_reset_idle: assert property ($past(sys_rst) |-> !xferValid && !pready)
      else $error("output active right after reset");
   chk_standby_clear: assert property ($past(standby) |-> !xferValid)
      else $error("command survived standby");
   cov_auto: cover property (xferValid && xferCode == REQ_AUTO);
   cov_stall: cover property (xferValid && !xferReady);
   cov_err: cover property (pslverr);
endmodule
bind drss_top drss_asserts chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .standby(standby),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .xferValid(xferValid), .xferChan(xferChan), .xferCode(xferCode), .xferReady(xferReady));

//--- testbench/drss_periph_model.sv
// Peripheral modules that raise their interrupt lines as transfer triggers.
`timescale 1ns/1ps
module drss_periph_model (
   input wire logic clk_sys, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic fire, // Raise the lines in fireMask.
   input wire logic [31:0] fireMask, // Lines to raise, bit n is code n.
   input wire logic [3:0] holdLen, // Cycles a line stays high after the first; long means slow.
   output logic [31:0] periphReq // Interrupt request levels.
);
   logic [3:0] holdCnt;
   // Each raised line is one interrupt; it drops after holdLen so the next is a new edge.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         periphReq <= 32'h0000_0000;
         holdCnt <= 4'h0;
      end else if (fire) begin
         periphReq <= periphReq | fireMask;
         holdCnt <= holdLen;
      end else if (holdCnt != 4'h0) begin
         holdCnt <= holdCnt - 4'h1;
      end else begin
         periphReq <= 32'h0000_0000;
      end
   end
endmodule

//--- testbench/testbench.sv
// Self-checking bench of the request selector.
`timescale 1ns/1ps
module testbench;
   import drss_pkg::*;
   logic clk_sys, sys_rst, standby, psel, penable, pwrite, pready, pslverr, nmiIn, addrErrIn;
   logic xferValid, xferReady, fire;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, periphReq, fireMask;
   logic [1:0] xferChan;
   logic [4:0] xferCode;
   logic [3:0] holdLen;
   int bad_count, cmp_count, cyc;
   localparam logic [7:0] OPR = DMA_OPERATION_OFS;
   drss_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .standby(standby), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periphReq(periphReq), .nmiIn(nmiIn),
      .addrErrIn(addrErrIn), .xferValid(xferValid), .xferChan(xferChan),
      .xferCode(xferCode), .xferReady(xferReady));
   drss_periph_model periph (.clk_sys(clk_sys), .sys_rst(sys_rst), .fire(fire),
      .fireMask(fireMask), .holdLen(holdLen), .periphReq(periphReq));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 50 ns and a cycle ceiling well above the planned run.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 5000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk("read data", exp, r);
      chk("error flag", {31'h0, expErr}, {31'h0, e});
   endtask
   function automatic logic [31:0] ctl(input logic [4:0] code);
      return (32'(code) << REQ_SEL_LSB) | 32'h0000_0001;
   endfunction
   // Waits for a command, checks it, and accepts it after a stall of st cycles.
   task automatic take(input logic [1:0] ch, input logic [4:0] code, input int st);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (xferValid !== 1'b1 && n < 40);
      chk("command valid", 32'h1, {31'h0, xferValid});
      repeat (st) @(posedge clk_sys);
      chk("command chan", {30'h0, ch}, {30'h0, xferChan});
      chk("command code", {27'h0, code}, {27'h0, xferCode});
      xferReady <= 1'b1;
      @(posedge clk_sys);
      xferReady <= 1'b0;
   endtask
   task automatic none(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         chk("no command", 32'h0, {31'h0, xferValid});
      end
   endtask
   task automatic pulse(input logic [31:0] m, input logic [3:0] h);
      fireMask <= m;
      holdLen <= h;
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_regs();
      rd(CHAN_CTRL_BASE, CTRL_RESET, 1'b0);
      rd(XFER_COUNT_BASE + 8'h0C, 32'h0, 1'b0);
      rd(OPR, 32'h0, 1'b0);
      rd(8'h24, 32'h0, 1'b1);
      wr(8'h24, 32'hFFFF_FFFF);
   endtask
   // Auto mode issues one unit per count, stalled engine, then the end flag.
   task automatic s_auto();
      wr(OPR, 32'h1);
      wr(XFER_COUNT_BASE, 32'h3);
      wr(CHAN_CTRL_BASE, ctl(REQ_AUTO));
      take(2'd0, REQ_AUTO, 3);
      take(2'd0, REQ_AUTO, 0);
      take(2'd0, REQ_AUTO, 0);
      none(6);
      rd(CHAN_CTRL_BASE, 32'h3, 1'b0);
      rd(XFER_COUNT_BASE, 32'h0, 1'b0);
   endtask
   // The nmi flag blocks an enabled auto channel until cleared; the address error flag is only set and cleared.
   task automatic s_abort();
      nmiIn <= 1'b1;
      @(posedge clk_sys);
      nmiIn <= 1'b0;
      rd(OPR, 32'h3, 1'b0);
      wr(XFER_COUNT_BASE, 32'h2);
      wr(CHAN_CTRL_BASE, ctl(REQ_AUTO));
      none(8);
      wr(OPR, 32'h1);
      take(2'd0, REQ_AUTO, 0);
      take(2'd0, REQ_AUTO, 0);
      addrErrIn <= 1'b1;
      @(posedge clk_sys);
      addrErrIn <= 1'b0;
      rd(OPR, 32'h5, 1'b0);
      wr(OPR, 32'h1);
      rd(OPR, 32'h1, 1'b0);
   endtask
   // Peripheral lines by code, and a reserved code that never requests.
   task automatic s_periph();
      wr(XFER_COUNT_BASE + 8'h04, 32'h1);
      wr(XFER_COUNT_BASE + 8'h08, 32'h1);
      wr(XFER_COUNT_BASE + 8'h0C, 32'h1);
      wr(CHAN_CTRL_BASE + 8'h04, ctl(REQ_RX4));
      wr(CHAN_CTRL_BASE + 8'h08, ctl(REQ_TX0));
      wr(CHAN_CTRL_BASE + 8'h0C, ctl(5'h0D));
      none(4);
      pulse(32'h1 << REQ_RX4, 4'h1);
      take(2'd1, REQ_RX4, 0);
      pulse(32'h1 << REQ_TX0, 4'h1);
      take(2'd2, REQ_TX0, 0);
      pulse(32'h1 << 13, 4'h1);
      none(10);
      wr(CHAN_CTRL_BASE + 8'h0C, ctl(REQ_CAN_RX));
      pulse(32'h1 << REQ_CAN_RX, 4'h1);
      take(2'd3, REQ_CAN_RX, 0);
   endtask
   // Simultaneous requests are issued lowest channel first.
   task automatic s_prio();
      rd(CHAN_CTRL_BASE, 32'h3, 1'b0);
      rd(CHAN_CTRL_BASE + 8'h04, ctl(REQ_RX4) | 32'h2, 1'b0);
      wr(XFER_COUNT_BASE, 32'h1);
      wr(XFER_COUNT_BASE + 8'h04, 32'h1);
      wr(CHAN_CTRL_BASE + 8'h04, ctl(REQ_CONV0));
      wr(CHAN_CTRL_BASE, ctl(REQ_TIMER_LAST));
      pulse((32'h1 << REQ_CONV0) | (32'h1 << REQ_TIMER_LAST), 4'h6);
      take(2'd0, REQ_TIMER_LAST, 4);
      take(2'd1, REQ_CONV0, 0);
      standby <= 1'b1;
      @(posedge clk_sys);
      standby <= 1'b0;
      rd(CHAN_CTRL_BASE, 32'h0, 1'b0);
      rd(OPR, 32'h0, 1'b0);
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Main sequence: reset for eight cycles, then each scenario in turn.
   initial begin
      {sys_rst, standby, psel, penable, pwrite, nmiIn, addrErrIn, xferReady, fire} = 9'h100;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fireMask = 32'h0000_0000;
      holdLen = 4'h0;
      bad_count = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      s_regs();
      s_auto();
      s_abort();
      s_periph();
      s_prio();
      complete_run();
   end
endmodule
